// ===== common/iem_pkg.sv
/*
 * Constants, types and state layout for the I2C EEPROM master controller.
 * Assumes a 200 MHz system clock; long waits are overridable at the top module.
 */
package iem_pkg;

    localparam int unsigned IEM_CLK_MHZ  = 200;
    localparam int unsigned IEM_SCL_KHZ  = 100;
    localparam int unsigned IEM_TBUF_NS  = 4700;
    localparam int unsigned IEM_T30_MS   = 30;
    localparam int unsigned IEM_TIDLE_MS = 4;
    localparam int unsigned IEM_TARB_MS  = 1920;

    // Half of the 100 kHz bit period; quarter places repeated START and STOP edges
    localparam logic [9:0]  IEM_HALF_CYC  = 10'(IEM_CLK_MHZ * 1000 / (2 * IEM_SCL_KHZ));
    localparam logic [9:0]  IEM_QTR_CYC   = 10'(IEM_CLK_MHZ * 1000 / (4 * IEM_SCL_KHZ));
    localparam logic [31:0] IEM_TBUF_CYC  = 32'((IEM_TBUF_NS * IEM_CLK_MHZ + 999) / 1000);
    localparam logic [31:0] IEM_T30_CYC   = 32'(IEM_T30_MS * IEM_CLK_MHZ * 1000);
    localparam logic [31:0] IEM_TIDLE_CYC = 32'(IEM_TIDLE_MS * IEM_CLK_MHZ * 1000);
    localparam logic [31:0] IEM_TARB_CYC  = 32'(IEM_TARB_MS * IEM_CLK_MHZ * 1000);

    localparam logic [1:0]  IEM_CMD_READ   = 2'h0;
    localparam logic [1:0]  IEM_CMD_WRITE  = 2'h1;
    localparam logic [1:0]  IEM_CMD_RELOAD = 2'h2;
    localparam logic [3:0]  IEM_CTRL_CODE  = 4'hA;
    localparam logic [3:0]  IEM_ACK_BIT    = 4'h8;

    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_LOAD   = 7'h02,
        ST_WFREE  = 7'h04,
        ST_START  = 7'h08,
        ST_SEND   = 7'h10,
        ST_RSTART = 7'h20,
        ST_STOP   = 7'h40
    } iem_st_t;

    typedef enum logic [7:0] {
        PH_CW   = 8'h01,
        PH_AH   = 8'h02,
        PH_AL   = 8'h04,
        PH_DATA = 8'h08,
        PH_CR   = 8'h10,
        PH_RD   = 8'h20,
        PH_POLL = 8'h40,
        PH_FIN  = 8'h80
    } iem_ph_t;

    typedef enum logic [2:0] {
        SP_LOW  = 3'h1,
        SP_RISE = 3'h2,
        SP_HIGH = 3'h4
    } iem_sp_t;

    typedef struct packed {
        iem_st_t     st;
        iem_ph_t     ph;
        iem_sp_t     sp;
        logic [3:0]  bitn;
        logic [9:0]  cnt;
        logic [31:0] stc;
        logic [31:0] ptc;
        logic [31:0] atc;
        logic [31:0] bcc;
        logic [7:0]  sh;
        logic [7:0]  data;
        logic        busy;
        logic        tout;
        logic        lreq;
        logic        scl_d;
        logic        sda_d;
        logic        nack;
        logic        won;
        logic        bus_busy;
        logic        stop_seen;
        logic        init;
        logic [1:0]  scl_s;
        logic [1:0]  sda_s;
        logic        scl_p;
        logic        sda_p;
    } iem_state_t;

    localparam iem_state_t IEM_RST = '{st: ST_IDLE, ph: PH_CW, sp: SP_LOW,
                                       bus_busy: 1'b1, init: 1'b1, default: '0};

    function automatic logic [31:0] iem_sat(input logic [31:0] v);
        iem_sat = (v == 32'hFFFF_FFFF) ? v : v + 32'h0000_0001;
    endfunction : iem_sat

endpackage : iem_pkg

// ===== rtl/iem_ctrl.sv
/*
 * Standard-mode I2C master for single byte reads and writes of a serial EEPROM,
 * with bus-busy tracking, clock synchronisation, arbitration and timeouts.
 * Assumes open-drain pads resolved outside; command fields held while BUSY.
 */
`timescale 1ns/1ps

module iem_ctrl
    import iem_pkg::*;
#(
    parameter logic [31:0] T30_CYC   = IEM_T30_CYC,
    parameter logic [31:0] TIDLE_CYC = IEM_TIDLE_CYC,
    parameter logic [31:0] TARB_CYC  = IEM_TARB_CYC
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RST_B,
    input  wire logic        CE,
    input  wire logic [1:0]  CMD_SEL,
    input  wire logic [15:0] LOC,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WDATA_LD,
    input  wire logic        BUSY_SET,
    input  wire logic        TIMEOUT_CLR,
    input  wire logic        ADDR2,
    input  wire logic        MGMT_I2C,
    input  wire logic        LOAD_DONE,
    input  wire logic        SCL_I,
    output logic             SCL_O,
    output logic             SCL_OE_B,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE_B,
    output logic             BUSY,
    output logic             TIMEOUT,
    output logic [7:0]       RDATA,
    output logic             LOAD_REQ
);

    iem_state_t q_ff;
    iem_state_t nxt_q;
    logic       scl_i;
    logic       sda_i;
    logic       start_det;
    logic       stop_det;
    logic       abort;
    logic       lost;
    logic       bit_end;
    logic       go_byte;
    iem_ph_t    nph;

    function automatic logic [7:0] iem_byte(
        input iem_ph_t     p,
        input logic [15:0] loc,
        input logic [7:0]  d,
        input logic        a2
    );
        case (p)
            PH_CW:   iem_byte = {IEM_CTRL_CODE, a2 ? 3'h0 : loc[10:8], 1'b0};
            PH_AH:   iem_byte = loc[15:8];
            PH_AL:   iem_byte = loc[7:0];
            PH_DATA: iem_byte = d;
            PH_CR:   iem_byte = {IEM_CTRL_CODE, a2 ? 3'h0 : loc[10:8], 1'b1};
            PH_POLL: iem_byte = {IEM_CTRL_CODE, 3'h0, 1'b0};
            default: iem_byte = 8'h00;
        endcase
    endfunction : iem_byte

    assign scl_i     = q_ff.scl_s[1];
    assign sda_i     = q_ff.sda_s[1];
    assign start_det = scl_i & q_ff.scl_p & q_ff.sda_p & ~sda_i;
    assign stop_det  = scl_i & q_ff.scl_p & ~q_ff.sda_p & sda_i;

    always_comb begin
        nxt_q   = q_ff;
        abort   = 1'b0;
        lost    = 1'b0;
        bit_end = 1'b0;
        go_byte = 1'b0;
        nph     = q_ff.ph;

        // Pins pass two flops before any logic looks at them
        nxt_q.scl_s = {q_ff.scl_s[0], SCL_I};
        nxt_q.sda_s = {q_ff.sda_s[0], SDA_I};
        nxt_q.scl_p = scl_i;
        nxt_q.sda_p = sda_i;
        nxt_q.lreq  = 1'b0;
        nxt_q.init  = 1'b0;
        nxt_q.ptc   = iem_sat(q_ff.ptc);

        if (scl_i && sda_i) begin
            nxt_q.bcc = iem_sat(q_ff.bcc);
        end else begin
            nxt_q.bcc = 32'h0000_0000;
        end
        if (stop_det) begin
            nxt_q.stop_seen = 1'b1;
            nxt_q.bcc       = 32'h0000_0000;
        end
        // free after STOP or long idle
        if (q_ff.bus_busy && ((q_ff.stop_seen && q_ff.bcc >= IEM_TBUF_CYC) || q_ff.bcc >= TIDLE_CYC)) begin
            nxt_q.bus_busy = 1'b0;
        end
        if (q_ff.init && !MGMT_I2C) begin
            nxt_q.bus_busy = 1'b0;
        end
        if (start_det) begin
            nxt_q.bus_busy  = 1'b1;
            nxt_q.stop_seen = 1'b0;
        end

        if (TIMEOUT_CLR) begin
            nxt_q.tout = 1'b0;
        end
        if (WDATA_LD && !q_ff.busy) begin
            nxt_q.data = WDATA;
        end

        if (q_ff.st != ST_IDLE && q_ff.st != ST_LOAD && !q_ff.won) begin
            nxt_q.atc = iem_sat(q_ff.atc);
            if (q_ff.atc >= TARB_CYC) begin
                abort = 1'b1;
            end
        end

        // Shared bit engine for data bits, repeated START and STOP
        if (q_ff.st == ST_SEND || q_ff.st == ST_RSTART || q_ff.st == ST_STOP) begin
            case (q_ff.sp)
                SP_LOW: begin
                    nxt_q.scl_d = 1'b1;
                    nxt_q.cnt   = q_ff.cnt + 10'h001;
                    if (q_ff.st == ST_STOP) begin
                        nxt_q.sda_d = 1'b1;
                    end else if (q_ff.st == ST_SEND && q_ff.bitn != IEM_ACK_BIT && q_ff.ph != PH_RD) begin
                        nxt_q.sda_d = ~q_ff.sh[7];
                    end else begin
                        nxt_q.sda_d = 1'b0;
                    end
                    if (q_ff.cnt == IEM_HALF_CYC - 10'h001) begin
                        nxt_q.scl_d = 1'b0;
                        nxt_q.sp    = SP_RISE;
                        nxt_q.cnt   = 10'h000;
                        nxt_q.stc   = 32'h0000_0000;
                    end
                end
                SP_RISE: begin
                    if (scl_i) begin
                        nxt_q.sp  = SP_HIGH;
                        nxt_q.cnt = 10'h000;
                    end else begin
                        nxt_q.stc = iem_sat(q_ff.stc);
                        if (q_ff.stc >= T30_CYC) begin
                            abort = 1'b1;
                        end
                    end
                end
                SP_HIGH: begin
                    nxt_q.cnt = q_ff.cnt + 10'h001;
                    if (q_ff.cnt == 10'h000 && q_ff.st == ST_SEND) begin
                        if (q_ff.bitn == IEM_ACK_BIT) begin
                            nxt_q.nack = sda_i;
                        end else if (q_ff.ph == PH_RD) begin
                            nxt_q.sh = {q_ff.sh[6:0], sda_i};
                        end else if (!q_ff.sda_d && !sda_i) begin
                            lost = 1'b1;
                        end
                    end
                    if (q_ff.cnt == IEM_QTR_CYC && q_ff.st != ST_SEND) begin
                        nxt_q.sda_d = (q_ff.st == ST_RSTART);
                    end
                    if (!scl_i && q_ff.cnt != 10'h000) begin
                        bit_end = 1'b1;
                    end
                    if (q_ff.cnt == IEM_HALF_CYC - 10'h001) begin
                        bit_end = 1'b1;
                    end
                end
                default: begin
                    nxt_q.sp = SP_LOW;
                end
            endcase
        end

        case (q_ff.st)
            ST_IDLE: begin
                if (BUSY_SET) begin
                    nxt_q.busy = 1'b1;
                    nxt_q.won  = 1'b0;
                    nxt_q.atc  = 32'h0000_0000;
                    nxt_q.ph   = PH_CW;
                    case (CMD_SEL)
                        IEM_CMD_READ: begin
                            nxt_q.st = ST_WFREE;
                        end
                        IEM_CMD_WRITE: begin
                            nxt_q.st = ST_WFREE;
                        end
                        IEM_CMD_RELOAD: begin
                            nxt_q.st   = ST_LOAD;
                            nxt_q.lreq = 1'b1;
                        end
                        default: begin
                            nxt_q.busy = 1'b0;
                        end
                    endcase
                end
            end
            ST_LOAD: begin
                if (LOAD_DONE) begin
                    nxt_q.busy = 1'b0;
                    nxt_q.st   = ST_IDLE;
                end
            end
            ST_WFREE: begin
                if (!q_ff.bus_busy && scl_i && sda_i) begin
                    nxt_q.st    = ST_START;
                    nxt_q.sda_d = 1'b1;
                    nxt_q.cnt   = 10'h000;
                end
            end
            ST_START: begin
                nxt_q.cnt = q_ff.cnt + 10'h001;
                if (q_ff.cnt == IEM_HALF_CYC - 10'h001) begin
                    nxt_q.scl_d = 1'b1;
                    go_byte     = 1'b1;
                end
            end
            ST_SEND: begin
                if (bit_end && q_ff.bitn != IEM_ACK_BIT) begin
                    nxt_q.bitn  = q_ff.bitn + 4'h1;
                    nxt_q.sp    = SP_LOW;
                    nxt_q.cnt   = 10'h000;
                    nxt_q.scl_d = 1'b1;
                    if (q_ff.ph != PH_RD) begin
                        nxt_q.sh = {q_ff.sh[6:0], 1'b0};
                    end
                end else if (bit_end) begin
                    nxt_q.scl_d = 1'b1;
                    nxt_q.sp    = SP_LOW;
                    nxt_q.cnt   = 10'h000;
                    case (q_ff.ph)
                        PH_CW: begin
                            nxt_q.won = 1'b1;
                            nph       = ADDR2 ? PH_AH : PH_AL;
                            go_byte   = 1'b1;
                        end
                        PH_AH: begin
                            nph     = PH_AL;
                            go_byte = 1'b1;
                        end
                        PH_AL: begin
                            if (CMD_SEL == IEM_CMD_WRITE) begin
                                nph     = PH_DATA;
                                go_byte = 1'b1;
                            end else begin
                                nxt_q.st = ST_RSTART;
                            end
                        end
                        PH_DATA: begin
                            nxt_q.ph  = PH_POLL;
                            nxt_q.st  = ST_STOP;
                            nxt_q.ptc = 32'h0000_0000;
                            nxt_q.atc = 32'h0000_0000;
                        end
                        PH_CR: begin
                            nph     = PH_RD;
                            go_byte = 1'b1;
                        end
                        PH_RD: begin
                            nxt_q.data = q_ff.sh;
                            nxt_q.st   = ST_STOP;
                        end
                        PH_POLL: begin
                            nxt_q.won = 1'b1;
                            if (!q_ff.nack) begin
                                nxt_q.ph = PH_FIN;
                                nxt_q.st = ST_RSTART;
                            end else begin
                                nxt_q.st = ST_STOP;
                            end
                        end
                        default: begin
                            nxt_q.st = ST_STOP;
                        end
                    endcase
                    if (q_ff.nack && q_ff.ph != PH_RD && q_ff.ph != PH_POLL) begin
                        abort = 1'b1;
                    end
                    // timer checked only after a nack
                    if (q_ff.nack && q_ff.ph == PH_POLL && q_ff.ptc >= T30_CYC) begin
                        abort = 1'b1;
                    end
                end
            end
            ST_RSTART: begin
                if (bit_end) begin
                    nxt_q.scl_d = 1'b1;
                    nxt_q.sp    = SP_LOW;
                    nxt_q.cnt   = 10'h000;
                    if (q_ff.ph == PH_FIN) begin
                        nxt_q.st = ST_STOP;
                    end else begin
                        nph     = PH_CR;
                        go_byte = 1'b1;
                    end
                end
            end
            ST_STOP: begin
                if (bit_end) begin
                    nxt_q.scl_d = 1'b0;
                    nxt_q.sda_d = 1'b0;
                    nxt_q.sp    = SP_LOW;
                    nxt_q.cnt   = 10'h000;
                    if (q_ff.ph == PH_POLL) begin
                        nxt_q.st  = ST_WFREE;
                        nxt_q.won = 1'b0;
                    end else begin
                        nxt_q.st   = ST_IDLE;
                        nxt_q.busy = 1'b0;
                    end
                end
            end
            default: begin
                nxt_q.st = ST_IDLE;
            end
        endcase

        if (go_byte) begin
            nxt_q.st   = ST_SEND;
            nxt_q.ph   = nph;
            nxt_q.sp   = SP_LOW;
            nxt_q.bitn = 4'h0;
            nxt_q.cnt  = 10'h000;
            nxt_q.sh   = iem_byte(nph, LOC, q_ff.data, ADDR2);
        end

        if (lost) begin
            nxt_q.scl_d = 1'b0;
            nxt_q.sda_d = 1'b0;
            nxt_q.won   = 1'b0;
            nxt_q.st    = ST_WFREE;
            nxt_q.ph = (q_ff.ph == PH_POLL) ? PH_POLL : PH_CW;
        end

        if (abort) begin
            nxt_q.st    = ST_IDLE;
            nxt_q.busy  = 1'b0;
            nxt_q.tout  = 1'b1;
            nxt_q.scl_d = 1'b0;
            nxt_q.sda_d = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            q_ff <= IEM_RST;
        end else if (CE) begin
            q_ff <= nxt_q;
        end
    end

    assign SCL_O    = 1'b0;
    assign SDA_O    = 1'b0;
    assign SCL_OE_B = ~q_ff.scl_d;
    assign SDA_OE_B = ~q_ff.sda_d;
    assign BUSY     = q_ff.busy;
    assign TIMEOUT  = q_ff.tout;
    assign RDATA    = q_ff.data;
    assign LOAD_REQ = q_ff.lreq;

endmodule : iem_ctrl

// ===== tb/iem_ctrl_properties.sv
/* Port checker for iem_ctrl, attached by bind.
   Assumes one clock domain and the async low reset. */
`timescale 1ns/1ps
module iem_ctrl_chk
    import iem_pkg::*;
(
    input wire logic       CLK_SYS,
    input wire logic       RST_B,
    input wire logic       CE,
    input wire logic [1:0] CMD_SEL,
    input wire logic [7:0] WDATA,
    input wire logic       WDATA_LD,
    input wire logic       BUSY_SET,
    input wire logic       TIMEOUT_CLR,
    input wire logic       LOAD_DONE,
    input wire logic       SCL_I,
    input wire logic       SCL_OE_B,
    input wire logic       SDA_OE_B,
    input wire logic       BUSY,
    input wire logic       TIMEOUT,
    input wire logic [7:0] RDATA,
    input wire logic       LOAD_REQ
);
    logic [15:0] lcnt_ff;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    // Length of our own clock low drive
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B)
            lcnt_ff <= 16'h0000;
        else
            lcnt_ff <= SCL_OE_B ? 16'h0000 : lcnt_ff + 16'h0001;
    end
    sequence s_take(logic [1:0] c);
        BUSY_SET && !BUSY && CE && CMD_SEL == c;
    endsequence
    sequence s_held_low;
        $rose(SCL_OE_B) ##1 !SCL_I [*8];
    endsequence
    a_busy_start: assert property (BUSY_SET && !BUSY && CE && CMD_SEL != 2'h3 |=> BUSY)
        else $error("busy did not rise on start");
    a_noop_cmd: assert property (s_take(2'h3) |=> !BUSY && !LOAD_REQ)
        else $error("unused command started work");
    a_reload_req: assert property (s_take(IEM_CMD_RELOAD) |=> LOAD_REQ && BUSY)
        else $error("reload did not request loader");
    a_reload_end: assert property (BUSY && CE && CMD_SEL == IEM_CMD_RELOAD && LOAD_DONE |=> !BUSY)
        else $error("reload busy outlived loader");
    a_tout_sticky: assert property (TIMEOUT && !TIMEOUT_CLR |=> TIMEOUT)
        else $error("timeout flag dropped by itself");
    a_tout_clear: assert property (TIMEOUT_CLR && CE && !BUSY |=> !TIMEOUT)
        else $error("timeout flag not cleared");
    a_idle_lines: assert property (!BUSY && !$past(BUSY) |-> SCL_OE_B && SDA_OE_B)
        else $error("lines driven while idle");
    a_data_load: assert property (WDATA_LD && CE && !BUSY |=> RDATA == $past(WDATA))
        else $error("data register not loaded");
    a_scl_low: assert property ($rose(SCL_OE_B) && BUSY |-> lcnt_ff >= 16'h03DE)
        else $error("clock low half too short");
    a_stretch_wait: assert property (s_held_low |-> SCL_OE_B)
        else $error("clock driven during stretch");
endmodule : iem_ctrl_chk

bind iem_ctrl iem_ctrl_chk u_chk (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .CE(CE), .CMD_SEL(CMD_SEL),
    .WDATA(WDATA), .WDATA_LD(WDATA_LD), .BUSY_SET(BUSY_SET), .TIMEOUT_CLR(TIMEOUT_CLR),
    .LOAD_DONE(LOAD_DONE), .SCL_I(SCL_I), .SCL_OE_B(SCL_OE_B), .SDA_OE_B(SDA_OE_B),
    .BUSY(BUSY), .TIMEOUT(TIMEOUT), .RDATA(RDATA), .LOAD_REQ(LOAD_REQ));

// ===== tb/iem_eeprom.sv
/* Behavioural serial EEPROM on the wired lines.
   Assumes pulled-up lines; never starts a transfer itself. */
`timescale 1ns/1ps
module iem_eeprom #(
    parameter logic [7:0] RD_BYTE = 8'h5C
) (
    input  wire logic  scl,
    input  wire logic  sda,
    input  wire logic  nack,
    input  wire logic  hold,
    output logic       scl_lo,
    output logic       sda_lo,
    output logic [7:0] ctl_w,
    output logic [7:0] addr_b
);
    logic [7:0] b;
    assign scl_lo = hold;
    task automatic rx(output logic [7:0] v);
        repeat (8) begin
            @(posedge scl);
            v = {v[6:0], sda};
        end
    endtask : rx
    task automatic ack();
        @(negedge scl);
        #20 sda_lo = !nack;
        @(negedge scl);
        #20;
    endtask : ack
    task automatic xfer();
        rx(b);
        ack();
        if (b[0]) begin
            for (int i = 7; i >= 0; i--) begin
                sda_lo = !RD_BYTE[i];
                @(negedge scl);
                #20;
            end
        end else begin
            ctl_w = b;
            sda_lo = 1'b0;
            rx(b);
            addr_b = b;
            ack();
        end
        sda_lo = 1'b0;
    endtask : xfer
    // only answers, a new START restarts decoding
    initial begin
        sda_lo = 1'b0;
        ctl_w = 8'h00;
        addr_b = 8'h00;
        forever begin
            @(negedge sda iff scl === 1'b1);
            disable fork;
            fork
                xfer();
            join_none
        end
    end
endmodule : iem_eeprom

// ===== tb/testbench.sv
/* Self-checking bench for iem_ctrl with an EEPROM model.
   Assumes 200 MHz clock and shortened timeouts. */
`timescale 1ns/1ps
module testbench
    import iem_pkg::*;
;
    typedef struct packed {
        logic [1:0] cmd;
        logic       nack;
        logic       tout;
    } iem_row_t;
    localparam logic [7:0]  RD_BYTE = 8'h5C;
    localparam logic [15:0] LOC_V   = 16'h0536;
    iem_row_t    rows [3] = '{'{IEM_CMD_RELOAD, 1'b0, 1'b0}, '{2'h3, 1'b0, 1'b0}, '{IEM_CMD_READ, 1'b1, 1'b1}};
    logic        CLK_SYS, RST_B, CE, MGMT_I2C, WDATA_LD, BUSY_SET, TIMEOUT_CLR, LOAD_DONE, nack, hold;
    logic [1:0]  CMD_SEL;
    logic [15:0] LOC;
    logic [7:0]  WDATA;
    wire         scl, sda, scl_lo, sda_lo, SCL_O, SCL_OE_B, SDA_O, SDA_OE_B, BUSY, TIMEOUT, LOAD_REQ;
    wire [7:0]   RDATA, ctl_w, addr_b;
    int          errors, comparisons;
    assign scl = SCL_OE_B & !scl_lo;
    assign sda = SDA_OE_B & !sda_lo;
    iem_ctrl #(.T30_CYC(32'h0000_0FA0), .TIDLE_CYC(32'h0000_0BB8), .TARB_CYC(32'h0001_86A0)) uut (
        .CLK_SYS(CLK_SYS), .RST_B(RST_B), .CE(CE), .CMD_SEL(CMD_SEL), .LOC(LOC), .WDATA(WDATA),
        .WDATA_LD(WDATA_LD), .BUSY_SET(BUSY_SET), .TIMEOUT_CLR(TIMEOUT_CLR), .ADDR2(1'b0),
        .MGMT_I2C(MGMT_I2C), .LOAD_DONE(LOAD_DONE), .SCL_I(scl), .SCL_O(SCL_O), .SCL_OE_B(SCL_OE_B),
        .SDA_I(sda), .SDA_O(SDA_O), .SDA_OE_B(SDA_OE_B), .BUSY(BUSY), .TIMEOUT(TIMEOUT),
        .RDATA(RDATA), .LOAD_REQ(LOAD_REQ));
    iem_eeprom #(.RD_BYTE(RD_BYTE)) u_mem (.scl(scl), .sda(sda), .nack(nack), .hold(hold),
        .scl_lo(scl_lo), .sda_lo(sda_lo), .ctl_w(ctl_w), .addr_b(addr_b));
    always #2.5 CLK_SYS = ~CLK_SYS;
    // Loader answers one cycle after its request
    always @(posedge CLK_SYS) LOAD_DONE <= #1 LOAD_REQ;
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask : tick
    task automatic chk1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t flag got %b expected %b", $time, got, exp);
        end
    endtask : chk1
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t byte got %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task automatic close_out();
        $display("Counts: %0d compared, %0d mismatched", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out
    // Bounded wait for idle (sel 0) or for a low clock line (sel 1)
    task automatic wait_for(input int n, input logic sel);
        int i;
        for (i = 0; i < n && (sel ? scl !== 1'b0 : BUSY !== 1'b0); i++) tick(1);
        if (i == n) begin
            errors++;
            $display("ERROR %0t wait ran out", $time);
            close_out();
        end
    endtask : wait_for
    task automatic issue(input logic [1:0] c);
        CMD_SEL = c;
        tick(1);
        BUSY_SET = 1'b1;
        tick(1);
        BUSY_SET = 1'b0;
    endtask : issue
    task automatic clr();
        TIMEOUT_CLR = 1'b1;
        tick(1);
        TIMEOUT_CLR = 1'b0;
    endtask : clr
    initial begin
        CLK_SYS = 1'b0;
        RST_B = 1'b0;
        {WDATA_LD, BUSY_SET, TIMEOUT_CLR, nack, hold} = 5'h00;
        CE = 1'b1;
        MGMT_I2C = 1'b1;
        CMD_SEL = 2'h3;
        LOC = LOC_V;
        WDATA = 8'hC3;
        tick(8);
        RST_B = 1'b1;
        chk1(BUSY, 1'b0);
        chk1(TIMEOUT, 1'b0);
        chk1(SCL_OE_B & SDA_OE_B, 1'b1);
        chk8(RDATA, 8'h00);
        WDATA_LD = 1'b1;
        tick(1);
        WDATA_LD = 1'b0;
        chk8(RDATA, 8'hC3);
        $display("test reset and load done");
        // Load strobe while frozen must not reach the data register
        CE = 1'b0;
        WDATA = 8'h3C;
        WDATA_LD = 1'b1;
        tick(1);
        WDATA_LD = 1'b0;
        CE = 1'b1;
        chk8(RDATA, 8'hC3);
        $display("test freeze done");
        foreach (rows[k]) begin
            nack = rows[k].nack;
            clr();
            issue(rows[k].cmd);
            chk1(BUSY, rows[k].cmd != 2'h3);
            wait_for(40000, 1'b0);
            chk1(TIMEOUT, rows[k].tout);
            $display("test row %0d done", k);
        end
        nack = 1'b0;
        clr();
        issue(IEM_CMD_READ);
        wait_for(20000, 1'b1);
        hold = 1'b1;
        tick(2500);
        hold = 1'b0;
        BUSY_SET = 1'b1;
        tick(1);
        BUSY_SET = 1'b0;
        wait_for(100000, 1'b0);
        chk1(TIMEOUT, 1'b0);
        chk8(RDATA, RD_BYTE);
        chk8(ctl_w, {IEM_CTRL_CODE, LOC_V[10:8], 1'b0});
        chk8(addr_b, LOC_V[7:0]);
        $display("test stretched read done");
        issue(IEM_CMD_WRITE);
        wait_for(20000, 1'b1);
        hold = 1'b1;
        wait_for(20000, 1'b0);
        hold = 1'b0;
        chk1(TIMEOUT, 1'b1);
        clr();
        chk1(TIMEOUT, 1'b0);
        $display("test stretch timeout done");
        // Mid-run reset outside I2C mode: bus taken free at once
        MGMT_I2C = 1'b0;
        RST_B = 1'b0;
        tick(8);
        RST_B = 1'b1;
        chk1(BUSY, 1'b0);
        issue(IEM_CMD_READ);
        tick(4);
        chk1(SDA_OE_B, 1'b0);
        $display("test mid-run reset done");
        close_out();
    end
endmodule : testbench
